// *** verilog/ttd_dev.sv ***
// trace trigger debug unit: comparators, arming, trace fifo, register port
// Summary of operation
// RL1: each compare bit selects one or zero
// RL2: comparator b high byte ignored in full mode
// RL3: comparators survive end-run reset
// RL4: reset sets waiting; end-run reset keeps matches (here end-run reset clears waiting)
// RL5: match flags a, b, c since arming
// RL6: waiting flag mirrors arm while enabled
// RL7: trigger setup writable only while disarmed
// RL8: trace fifo holds eight words
// RL9: flow addresses, or event data only
// RL10: event modes read high and extension zero
// RL11: destination flow change stores current address
// RL12: taken branch stores previous address minus two
// RL13: begin storage waits, then fills eight
// RL14: event modes support begin storage only
// RL15: end storage runs until trigger, then disarms
// RL16: end trigger at flow address gets stored
// RL17: fifo readable only enabled and disarmed, in order
// RL18: breakpoint kind ignored without breakpoint enable
// RL19: end runs: qualification should match breakpoint kind
// RL20: begin runs: avoid tag-type breakpoint
// RL21: count shows words left; reads advance
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ttd_dev #(
  parameter int DEPTH = ttd_pkg::DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  ttd_link_if.dev lnk,
  output logic brk_force_o,
  output logic brk_tag_o,
  output logic armed_o
);
  localparam int AW = ttd_pkg::ADDR_W;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [7:0] cmp_hi [3];
  logic [7:0] cmp_lo [3];
  logic [7:0] cmp_x [3];
  logic [2:0] hit;
  logic [2:0] flag;
  logic en;
  logic tag;
  logic cpu_breakpoint_enable;
  logic loop1;
  logic waiting;
  logic [7:0] trg_reg;
  ttd_pkg::ttd_run_t state;
  ttd_pkg::ttd_run_t next_state;
  logic [AW-1:0] prev_addr;
  logic [AW-1:0] cof_addr;
  logic [AW-1:0] push_val;
  logic [AW-1:0] head;
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] cnt;
  logic [7:0] rd_val;
  logic trig;
  logic evt;
  logic full;
  logic armed;
  logic push;
  logic pop;
  logic run_done;
  logic arm_start;
  logic hard_rst;
  logic soft_rst;
  logic wr_ctl;
  logic wr_trg;
  logic rd_ok;
  logic any_cof;

  // an end run that ends in reset keeps its evidence for the debugger
  assign soft_rst = !rst_b_i && por_b_i && en && !trg_reg[ttd_pkg::TRG_BEGIN]; // see RL3
  assign hard_rst = !por_b_i || (!rst_b_i && !soft_rst);
  assign evt = trg_reg[3:0] == ttd_pkg::TRG_EVT_B;
  assign full = trg_reg[3:0] == ttd_pkg::TRG_FULL_AB;
  assign armed = state != ttd_pkg::RUN_IDLE;
  assign wr_ctl = lnk.reg_wr && (lnk.reg_sel == ttd_pkg::OFS_CTL);
  assign wr_trg = lnk.reg_wr && (lnk.reg_sel == ttd_pkg::OFS_TRG);
  assign rd_ok = en && !armed; // see RL17
  assign any_cof = |lnk.core_cof;
  assign head = mem[rptr];
  assign arm_start = wr_ctl && lnk.reg_wdata[ttd_pkg::CTL_ARM] &&
                     lnk.reg_wdata[ttd_pkg::CTL_EN] && !armed;

  for (genvar g = 0; g < 3; g++) begin : g_cmp
    localparam logic [3:0] OH = ttd_pkg::OFS_CMP_BASE + 4'(2 * g);
    localparam logic [3:0] OL = ttd_pkg::OFS_CMP_BASE + 4'(2 * g + 1);
    localparam logic [3:0] OX = ttd_pkg::OFS_CMPX_BASE + 4'(g);
    logic [AW-1:0] bus;

    always_ff @(posedge ref_clk_i) begin
      if (hard_rst) begin
        cmp_hi[g] <= ttd_pkg::CMP_RST;
        cmp_lo[g] <= ttd_pkg::CMP_RST;
        cmp_x[g] <= ttd_pkg::CMP_RST;
      end else if (!soft_rst && lnk.reg_wr) begin // see RL3
        if (lnk.reg_sel == OH) begin
          cmp_hi[g] <= lnk.reg_wdata;
        end
        if (lnk.reg_sel == OL) begin
          cmp_lo[g] <= lnk.reg_wdata;
        end
        if (lnk.reg_sel == OX) begin
          cmp_x[g] <= lnk.reg_wdata & ttd_pkg::CMPX_MASK;
        end
      end
    end

    // in full mode comparator b looks at the data bus low byte only
    assign bus = (g == 1 && full) ? {9'h000, lnk.core_data} : lnk.core_addr; // see RL2

    ttd_cmp u_cmp (
      .val_i({cmp_x[g][0], cmp_hi[g], cmp_lo[g]}),
      .bus_i(bus),
      .ign_hi_i(g == 1 && full),
      .hit_o(hit[g])
    );

    // flags gather only while armed; arming clears them first
    always_ff @(posedge ref_clk_i) begin
      if (hard_rst) begin
        flag[g] <= 1'b0;
      end else if (!soft_rst) begin // see RL4
        flag[g] <= (flag[g] && !arm_start) || (armed && hit[g]); // see RL5
      end
    end
  end

  always_comb begin
    case (trg_reg[3:0])
      ttd_pkg::TRG_A_ONLY: trig = hit[0];
      ttd_pkg::TRG_A_OR_B: trig = hit[0] || hit[1];
      ttd_pkg::TRG_A_THEN_B: trig = flag[0] && hit[1];
      ttd_pkg::TRG_EVT_B: trig = hit[1];
      ttd_pkg::TRG_FULL_AB: trig = hit[0] && hit[1];
      default: trig = 1'b0;
    endcase
  end

  assign cof_addr = lnk.core_cof[1] ? lnk.core_addr : prev_addr - ttd_pkg::BR_STEP; // see RL11, see RL12
  assign push_val = evt ? AW'(lnk.core_data) : cof_addr; // see RL9

  always_comb begin
    next_state = state;
    push = 1'b0;
    run_done = 1'b0;
    unique case (state)
      ttd_pkg::RUN_IDLE: next_state = state;
      ttd_pkg::RUN_END: begin
        push = any_cof; // see RL15, see RL16
        if (trig) begin
          next_state = ttd_pkg::RUN_IDLE; // see RL15
          run_done = 1'b1;
        end
      end
      ttd_pkg::RUN_WAIT: begin
        if (trig) begin
          next_state = ttd_pkg::RUN_BEGIN; // see RL13
          push = evt || any_cof;
        end
      end
      ttd_pkg::RUN_BEGIN: push = evt ? trig : any_cof;
    endcase
    if (push && state != ttd_pkg::RUN_END && cnt == CW'(DEPTH - 1)) begin
      next_state = ttd_pkg::RUN_IDLE; // see RL13
      run_done = 1'b1;
    end
    if (wr_ctl) begin
      if (!lnk.reg_wdata[ttd_pkg::CTL_ARM]) begin
        next_state = ttd_pkg::RUN_IDLE;
      end else if (arm_start) begin
        // event modes fall back to begin storage
        next_state = (trg_reg[ttd_pkg::TRG_BEGIN] || evt) ?
                     ttd_pkg::RUN_WAIT : ttd_pkg::RUN_END; // see RL14
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst || soft_rst) begin
      state <= ttd_pkg::RUN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      waiting <= ttd_pkg::WAIT_RST; // see RL4
    end else if (soft_rst) begin
      waiting <= 1'b0; // see RL4
    end else if (en) begin
      waiting <= next_state != ttd_pkg::RUN_IDLE; // see RL6, see RL15
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      en <= ttd_pkg::CTL_BIT_RST;
      tag <= ttd_pkg::CTL_BIT_RST;
      cpu_breakpoint_enable <= ttd_pkg::CTL_BIT_RST;
      loop1 <= ttd_pkg::CTL_BIT_RST;
    end else if (!soft_rst && wr_ctl) begin
      en <= lnk.reg_wdata[ttd_pkg::CTL_EN];
      tag <= lnk.reg_wdata[ttd_pkg::CTL_TAG];
      cpu_breakpoint_enable <= lnk.reg_wdata[ttd_pkg::CTL_BRK];
      loop1 <= lnk.reg_wdata[ttd_pkg::CTL_LOOP];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (hard_rst) begin
      trg_reg <= ttd_pkg::TRG_RST;
    end else if (!soft_rst && wr_trg && !armed) begin // see RL7
      trg_reg <= lnk.reg_wdata & ttd_pkg::TRG_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!por_b_i || !rst_b_i) begin
      prev_addr <= '0;
    end else begin
      prev_addr <= lnk.core_addr; // see RL12
    end
  end

  // no reset on the storage itself; fifo reads return the head entry even when the count is zero
  always_ff @(posedge ref_clk_i) begin
    if (push && por_b_i && rst_b_i) begin
      mem[wptr] <= push_val; // see RL8
    end
  end

  assign pop = lnk.reg_rd && (lnk.reg_sel == ttd_pkg::OFS_FL) && rd_ok && cnt != '0;

  // pointers wrap, so the depth must be a power of two
  always_ff @(posedge ref_clk_i) begin
    if (hard_rst || arm_start) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
    end else if (!soft_rst) begin
      if (push) begin
        wptr <= wptr + PW'(1);
        if (cnt == CW'(DEPTH)) begin
          rptr <= rptr + PW'(1); // end runs keep the newest words
        end else begin
          cnt <= cnt + CW'(1);
        end
      end else if (pop) begin
        rptr <= rptr + PW'(1); // see RL17, see RL21
        cnt <= cnt - CW'(1); // see RL21
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (lnk.reg_sel == ttd_pkg::OFS_CMP_BASE + 4'(2 * i)) begin
        rd_val = cmp_hi[i];
      end
      if (lnk.reg_sel == ttd_pkg::OFS_CMP_BASE + 4'(2 * i + 1)) begin
        rd_val = cmp_lo[i];
      end
      if (lnk.reg_sel == ttd_pkg::OFS_CMPX_BASE + 4'(i)) begin
        rd_val = cmp_x[i];
      end
    end
    if (lnk.reg_sel == ttd_pkg::OFS_FH && rd_ok && !evt) begin
      rd_val = head[15:8]; // see RL10
    end
    if (lnk.reg_sel == ttd_pkg::OFS_FL && rd_ok) begin
      rd_val = head[7:0];
    end
    if (lnk.reg_sel == ttd_pkg::OFS_FX && rd_ok && !evt) begin
      rd_val = {7'h00, head[16]}; // see RL10
    end
    if (lnk.reg_sel == ttd_pkg::OFS_CTL) begin
      rd_val = {en, armed, tag, cpu_breakpoint_enable, 3'h0, loop1};
    end
    if (lnk.reg_sel == ttd_pkg::OFS_TRG) begin
      rd_val = trg_reg;
    end
    if (lnk.reg_sel == ttd_pkg::OFS_STAT) begin
      rd_val = {flag[0], flag[1], flag[2], 4'h0, waiting}; // see RL5, see RL6
    end
    if (lnk.reg_sel == ttd_pkg::OFS_CNT) begin
      rd_val = 8'(cnt); // see RL21
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!por_b_i || !rst_b_i) begin
      lnk.reg_rdata <= 8'h00;
      lnk.reg_ack <= 1'b0;
      brk_force_o <= 1'b0;
      brk_tag_o <= 1'b0;
      armed_o <= 1'b0;
    end else begin
      lnk.reg_ack <= lnk.reg_rd || lnk.reg_wr;
      if (lnk.reg_rd) begin
        lnk.reg_rdata <= rd_val;
      end
      brk_force_o <= run_done && cpu_breakpoint_enable && !tag; // see RL18
      brk_tag_o <= run_done && cpu_breakpoint_enable && tag; // see RL18
      armed_o <= next_state != ttd_pkg::RUN_IDLE;
    end
  end
endmodule

// *** verilog/ttd_pkg.sv ***
// shared constants and types for the trace trigger debug unit
package ttd_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int DEPTH = 8;
  // device register offsets on the link
  localparam logic [3:0] OFS_CMP_BASE = 4'h0;
  localparam logic [3:0] OFS_FH = 4'h6;
  localparam logic [3:0] OFS_FL = 4'h7;
  localparam logic [3:0] OFS_CMPX_BASE = 4'h8;
  localparam logic [3:0] OFS_FX = 4'hb;
  localparam logic [3:0] OFS_CTL = 4'hc;
  localparam logic [3:0] OFS_TRG = 4'hd;
  localparam logic [3:0] OFS_STAT = 4'he;
  localparam logic [3:0] OFS_CNT = 4'hf;
  // field positions
  localparam int CTL_EN = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BRK = 4;
  localparam int CTL_LOOP = 0;
  localparam int TRG_QUAL = 7;
  localparam int TRG_BEGIN = 6;
  localparam logic [7:0] TRG_MASK = 8'hcf;
  localparam logic [7:0] CMPX_MASK = 8'he1;
  // values after reset
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] TRG_RST = 8'h00;
  localparam logic CTL_BIT_RST = 1'b0;
  localparam logic WAIT_RST = 1'b1;
  localparam logic [ADDR_W-1:0] BR_STEP = 17'h00002;
  typedef enum logic [3:0] {
    TRG_A_ONLY = 4'h0,
    TRG_A_OR_B = 4'h1,
    TRG_A_THEN_B = 4'h2,
    TRG_EVT_B = 4'h3,
    TRG_FULL_AB = 4'h4
  } ttd_trg_t;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_END = 2'b01,
    RUN_WAIT = 2'b10,
    RUN_BEGIN = 2'b11
  } ttd_run_t;
  // controller registers on the axi4-lite side
  localparam logic [3:0] HOST_CMD = 4'h0;
  localparam logic [3:0] HOST_STAT = 4'h4;
  localparam int CMD_WR = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** verilog/ttd_link_if.sv ***
// link between the debug unit and its controller: core bus plus register port
`timescale 1ns/1ns
interface ttd_link_if;
  logic [ttd_pkg::ADDR_W-1:0] core_addr;
  logic [ttd_pkg::DATA_W-1:0] core_data;
  logic [1:0] core_cof;
  logic [3:0] reg_sel;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  modport dev (
    input core_addr, core_data, core_cof, reg_sel, reg_wr, reg_rd, reg_wdata,
    output reg_rdata, reg_ack
  );
  modport host (
    output core_addr, core_data, core_cof, reg_sel, reg_wr, reg_rd, reg_wdata,
    input reg_rdata, reg_ack
  );
endinterface

// *** verilog/ttd_cmp.sv ***
// one address comparator
`timescale 1ns/1ns
module ttd_cmp (
  input wire logic [ttd_pkg::ADDR_W-1:0] val_i,
  input wire logic [ttd_pkg::ADDR_W-1:0] bus_i,
  input wire logic ign_hi_i,
  output logic hit_o
);
  localparam int AW = ttd_pkg::ADDR_W;

  // each value bit says whether its bus bit must be one or zero
  assign hit_o = (bus_i[7:0] == val_i[7:0]) &&
                 (ign_hi_i || (bus_i[AW-1:8] == val_i[AW-1:8])); // see RL1, see RL2
endmodule

// *** verilog/ttd_host.sv ***
// debug controller: axi4-lite command registers driving the unit's register port
`timescale 1ns/1ns
module ttd_host (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  ttd_link_if.host lnk,
  input wire logic [ttd_pkg::ADDR_W-1:0] core_addr_i,
  input wire logic [ttd_pkg::DATA_W-1:0] core_data_i,
  input wire logic [1:0] core_cof_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic s_axi_bvalid_o,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic s_axi_rvalid_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rready_i
);
  logic aw_got;
  logic w_got;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic busy;
  logic pend_rd;
  logic [7:0] rd_byte;
  logic [16:0] cmd_q;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_wr;
  logic cmd_ok;
  logic launch;

  assign aw_take = s_axi_awready_o && s_axi_awvalid_i;
  assign w_take = s_axi_wready_o && s_axi_wvalid_i;
  assign ar_take = s_axi_arready_o && s_axi_arvalid_i;
  assign do_wr = aw_got && w_got && !s_axi_bvalid_o;
  // a command needs its three low byte lanes and an idle port
  assign cmd_ok = awaddr_q == ttd_pkg::HOST_CMD && !busy && (&wstrb_q[2:0]);
  assign launch = do_wr && cmd_ok;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= ttd_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        aw_got <= 1'b0;
      end
      if (w_take) begin
        w_got <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        w_got <= 1'b0;
      end
      s_axi_awready_o <= !(aw_got || aw_take);
      s_axi_wready_o <= !(w_got || w_take);
      if (do_wr) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= cmd_ok ? ttd_pkg::RESP_OKAY : ttd_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.reg_sel <= 4'h0;
      lnk.reg_wdata <= 8'h00;
      busy <= 1'b0;
      pend_rd <= 1'b0;
      rd_byte <= 8'h00;
      cmd_q <= 17'h00000;
    end else begin
      lnk.reg_wr <= launch && wdata_q[ttd_pkg::CMD_WR];
      lnk.reg_rd <= launch && !wdata_q[ttd_pkg::CMD_WR];
      if (launch) begin
        lnk.reg_sel <= wdata_q[3:0];
        lnk.reg_wdata <= wdata_q[15:8];
        cmd_q <= wdata_q[16:0];
        busy <= 1'b1;
        pend_rd <= !wdata_q[ttd_pkg::CMD_WR];
      end else if (lnk.reg_ack) begin
        busy <= 1'b0;
        pend_rd <= 1'b0;
        if (pend_rd) begin
          rd_byte <= lnk.reg_rdata;
        end
      end
    end
  end

  // the core side is passed on registered, one cycle late
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      lnk.core_addr <= '0;
      lnk.core_data <= '0;
      lnk.core_cof <= 2'h0;
    end else begin
      lnk.core_addr <= core_addr_i;
      lnk.core_data <= core_data_i;
      lnk.core_cof <= core_cof_i; // see RL11, see RL12
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= ttd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_o <= !(ar_take || (s_axi_rvalid_o && !s_axi_rready_i));
      if (ar_take) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= ttd_pkg::RESP_OKAY;
        if (s_axi_araddr_i == ttd_pkg::HOST_STAT) begin
          s_axi_rdata_o <= {16'h0000, rd_byte, 7'h00, busy};
        end else if (s_axi_araddr_i == ttd_pkg::HOST_CMD) begin
          s_axi_rdata_o <= {15'h0000, cmd_q};
        end else begin
          s_axi_rdata_o <= 32'h00000000;
          s_axi_rresp_o <= ttd_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule

// *** dv/ttd_props.sv ***
// concurrent checks on the link between the debug unit and its controller
`timescale 1ns/1ns
module ttd_props #(
  parameter int DEPTH = ttd_pkg::DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack
);
  logic [3:0] trg_mode;
  // follows every trigger write; armed writes are not filtered, so keep mode 3 out of those
  always_ff @(posedge ref_clk_i) begin
    if (reg_wr && reg_sel == ttd_pkg::OFS_TRG) begin
      trg_mode <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_req;
    reg_wr || reg_rd;
  endsequence
  sequence s_evt_rd(logic [3:0] ofs);
    reg_rd && reg_sel == ofs && trg_mode == 4'h3;
  endsequence
  a_ack_follows_req: assert property (s_req |=> reg_ack)
    else $error("acknowledge missing after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("acknowledge without request");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_no_rd_wr: assert property (!(reg_rd && reg_wr))
    else $error("read and write in one cycle");
  a_evt_high_zero: assert property (s_evt_rd(ttd_pkg::OFS_FH) |=> reg_rdata == 8'h00)
    else $error("fifo high byte not zero in event mode");
  a_evt_ext_zero: assert property (s_evt_rd(ttd_pkg::OFS_FX) |=> reg_rdata == 8'h00)
    else $error("fifo extension not zero in event mode");
  a_count_bounded: assert property (reg_rd && reg_sel == ttd_pkg::OFS_CNT |=> reg_rdata <= DEPTH)
    else $error("fifo count above depth");
  a_status_fixed: assert property (reg_rd && reg_sel == ttd_pkg::OFS_STAT |=> reg_rdata[4:1] == 4'h0)
    else $error("status reserved bits set");
  a_ext_fixed: assert property (reg_rd && reg_sel == ttd_pkg::OFS_FX |=> reg_rdata[7:1] == 7'h00)
    else $error("fifo extension upper bits set");
endmodule

// *** dv/tb.sv ***
// self-checking bench: controller and debug unit joined over the link
`timescale 1ns/1ns
module tb;
  typedef struct {logic [3:0] o; logic [7:0] w; logic [7:0] e;} ttd_row_t;
  logic ref_clk, rst_b, por_b;
  logic [ttd_pkg::ADDR_W-1:0] c_addr;
  logic [7:0] c_data;
  logic [1:0] c_cof, bresp, rresp, r;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d32;
  logic brk_f, brk_t, armed;
  int error_cnt, cmp_count;
  int brk_n = 0;
  int brk_tn = 0;
  // mask bits of the extension registers are dropped on write
  ttd_row_t rows [9] = '{'{4'h0, 8'h12, 8'h12}, '{4'h1, 8'h34, 8'h34}, '{4'h2, 8'h56, 8'h56},
    '{4'h3, 8'h78, 8'h78}, '{4'h4, 8'h9a, 8'h9a}, '{4'h5, 8'hbc, 8'hbc},
    '{4'h8, 8'hfe, 8'he0}, '{4'h9, 8'h1e, 8'h00}, '{4'ha, 8'h01, 8'h01}};
  logic [16:0] flow [3] = '{17'h00100, 17'h0014e, 17'h00200};
  ttd_link_if lnk ();
  ttd_host ttd_host_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .lnk(lnk.host),
    .core_addr_i(c_addr), .core_data_i(c_data), .core_cof_i(c_cof),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bvalid_o(bvalid), .s_axi_bresp_o(bresp),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rvalid_o(rvalid), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rready_i(rready));
  ttd_dev #(.DEPTH(8)) ttd_dev_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .por_b_i(por_b),
    .lnk(lnk.dev), .brk_force_o(brk_f), .brk_tag_o(brk_t), .armed_o(armed));
  ttd_props #(.DEPTH(8)) ttd_props_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .reg_sel(lnk.reg_sel), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_wdata(lnk.reg_wdata),
    .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (brk_f === 1'b1) begin
      brk_n <= brk_n + 1;
    end
    if (brk_t === 1'b1) begin
      brk_tn <= brk_tn + 1;
    end
  end
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic fail_wait;
    error_cnt++;
    $display("unexpected wait: expected answer, seen none");
    end_of_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit aw_p, w_p, got;
    @(posedge ref_clk);
    aw_p = 1;
    w_p = 1;
    got = 0;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge ref_clk);
      if (aw_p && awready === 1'b1) begin aw_p = 0; awvalid <= 1'b0; end
      if (w_p && wready === 1'b1) begin w_p = 0; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin rs = bresp; got = 1; bready <= 1'b0; end
    end
    if (!got) fail_wait();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit ar_p, got;
    @(posedge ref_clk);
    ar_p = 1;
    got = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge ref_clk);
      if (ar_p && arready === 1'b1) begin ar_p = 0; arvalid <= 1'b0; end
      if (rvalid === 1'b1) begin d = rdata; rs = rresp; got = 1; rready <= 1'b0; end
    end
    if (!got) fail_wait();
  endtask
  // one device register access through the controller's command word, then poll busy
  task automatic dev_acc(input logic w, input logic [3:0] o, input logic [7:0] v,
    output logic [7:0] q);
    logic [31:0] st;
    logic [1:0] rs;
    axi_wr(ttd_pkg::HOST_CMD, {15'h0, w, v, 4'h0, o}, rs);
    repeat (2) @(posedge ref_clk);
    st = 32'h1;
    for (int n = 0; n < 20 && st[0] !== 1'b0; n++) axi_rd(ttd_pkg::HOST_STAT, st, rs);
    if (st[0] !== 1'b0) fail_wait();
    q = st[15:8];
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] v);
    logic [7:0] q;
    dev_acc(1'b1, o, v, q);
  endtask
  task automatic rdc(input logic [3:0] o, input logic [7:0] e, input string nm);
    logic [7:0] q;
    dev_acc(1'b0, o, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic core(input logic [16:0] a, input logic [7:0] d, input logic [1:0] c);
    @(posedge ref_clk);
    c_addr <= a; c_data <= d; c_cof <= c;
  endtask
  task automatic do_reset(input logic full);
    @(posedge ref_clk);
    rst_b <= 1'b0; por_b <= !full;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1; por_b <= 1'b1;
  endtask
  initial begin
    {error_cnt, cmp_count} = '0;
    {awvalid, wvalid, bready, arvalid, rready, rst_b, por_b} = '0;
    {awaddr, araddr, wdata, c_addr, c_data, c_cof} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1; por_b <= 1'b1;
    rdc(ttd_pkg::OFS_STAT, 8'h01, "status after reset");
    rdc(4'h2, 8'h00, "comparator b high after reset");
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].o, rows[i].w);
      rdc(rows[i].o, rows[i].e, "comparator register");
    end
    axi_wr(4'h8, 32'h0, r);
    chk("unmapped write response", ttd_pkg::RESP_SLVERR, r);
    axi_rd(4'hc, d32, r);
    chk("unmapped read response", ttd_pkg::RESP_SLVERR, r);
    chk("unmapped read data", 32'h0, d32);
    $display("test registers done");
    // end run: comparator a at 0x00200, flow changes before and at the trigger
    wr(4'h0, 8'h02); wr(4'h1, 8'h00); wr(4'h8, 8'h00);
    wr(ttd_pkg::OFS_TRG, 8'h80);
    wr(ttd_pkg::OFS_CTL, 8'h80);
    wr(ttd_pkg::OFS_CTL, 8'hf0);
    rdc(ttd_pkg::OFS_STAT, 8'h01, "waiting flag while armed");
    wr(ttd_pkg::OFS_TRG, 8'h45);
    core(17'h00100, 8'h00, 2'b10); core(17'h00150, 8'h00, 2'b00);
    core(17'h00160, 8'h00, 2'b01); core(17'h00200, 8'h00, 2'b10);
    core(17'h00300, 8'h00, 2'b10); core(17'h00000, 8'h00, 2'b00);
    repeat (4) @(posedge ref_clk);
    chk("armed after end trigger", 32'h0, armed);
    chk("force breakpoint pulses", 32'h0, brk_n);
    chk("tag breakpoint pulses", 32'h1, brk_tn);
    rdc(ttd_pkg::OFS_STAT, 8'h80, "status after end trigger");
    rdc(ttd_pkg::OFS_TRG, 8'h80, "trigger setup kept while armed");
    rdc(ttd_pkg::OFS_CNT, 8'h03, "count after end run");
    for (int i = 0; i < 3; i++) begin
      rdc(ttd_pkg::OFS_FH, flow[i][15:8], "fifo high");
      rdc(ttd_pkg::OFS_FX, {7'h0, flow[i][16]}, "fifo extension");
      rdc(ttd_pkg::OFS_FL, flow[i][7:0], "fifo low");
      rdc(ttd_pkg::OFS_CNT, 8'(2 - i), "count after pop");
    end
    $display("test end run done");
    do_reset(1'b0);
    rdc(4'h2, 8'h56, "comparator kept over end-run reset");
    rdc(ttd_pkg::OFS_STAT, 8'h80, "status after end-run reset");
    $display("test end-run reset done");
    // begin run in event mode on comparator b; nine hits, only eight fit
    wr(4'h2, 8'h04); wr(4'h3, 8'h00);
    wr(ttd_pkg::OFS_TRG, 8'h43);
    wr(ttd_pkg::OFS_CTL, 8'hd0);
    core(17'h00100, 8'h55, 2'b10);
    for (int i = 0; i < 9; i++) core(17'h00400, 8'(8'h10 + i), 2'b00);
    core(17'h00000, 8'h00, 2'b00);
    repeat (4) @(posedge ref_clk);
    rdc(ttd_pkg::OFS_CNT, 8'h08, "count after begin run");
    chk("force breakpoint after fill", 32'h1, brk_n);
    for (int i = 0; i < 8; i++) begin
      rdc(ttd_pkg::OFS_FH, 8'h00, "event fifo high");
      rdc(ttd_pkg::OFS_FX, 8'h00, "event fifo extension");
      rdc(ttd_pkg::OFS_FL, 8'(8'h10 + i), "event fifo data");
    end
    $display("test begin run done");
    // full mode: b high byte 0x04 ignored, b low byte meets the data bus
    wr(ttd_pkg::OFS_TRG, 8'h44);
    wr(ttd_pkg::OFS_CTL, 8'hc0);
    core(17'h00200, 8'h00, 2'b10);
    core(17'h00000, 8'h00, 2'b00);
    repeat (4) @(posedge ref_clk);
    rdc(ttd_pkg::OFS_CNT, 8'h01, "count after full-mode trigger");
    rdc(ttd_pkg::OFS_STAT, 8'hc1, "status during begin run");
    rdc(ttd_pkg::OFS_FL, 8'h00, "fifo hidden while armed");
    rdc(ttd_pkg::OFS_CNT, 8'h01, "count kept while armed");
    $display("test full mode done");
    do_reset(1'b1);
    rdc(ttd_pkg::OFS_STAT, 8'h01, "status after power-on reset");
    rdc(4'h2, 8'h00, "comparator after power-on reset");
    $display("test power-on reset done");
    end_of_test();
  end
endmodule
